// [design/scs_result_store.sv]
`timescale 1ns/1ps
`default_nettype none

module scs_result_store
	import scs_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               wr_en,
	input  wire logic [STORE_W-1:0] wr_data,
	output var  logic [STORE_W-1:0] rd_data
);

	// ---------------------------------------------------------------
	// output register: holds one result until the next latch
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rd_data <= STORE_RST;
		else if (wr_en)
			rd_data <= wr_data;
	end

endmodule : scs_result_store

`default_nettype wire

// [design/scs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer
	import scs_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              convert_start,
	input  wire logic              power_down,
	input  wire logic              cm_append,
	input  wire logic [1:0]        lane_mode,
	input  wire logic              echo_en,
	input  wire logic              cmp_high,
	input  wire logic [CM_W-1:0]   cm_code_in,
	input  wire logic              sck,
	input  wire logic              cs_n,
	output logic                   busy_or_clock_out,
	output logic                   track_hold,
	output logic                   powered,
	output logic [DIFF_W-1:0]      sar_trial,
	output logic [3:0]             sdo,
	output logic                   echo_clock
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] cnv_sync;
	logic       cnv_prev;
	logic [1:0] pd_sync;
	logic       start_edge;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnv_sync <= 2'h0;
			cnv_prev <= 1'b0;
			pd_sync  <= 2'h0;
		end
		else
		begin
			cnv_sync <= {cnv_sync[0], convert_start};
			cnv_prev <= cnv_sync[1];
			pd_sync  <= {pd_sync[0], power_down};
		end
	end

	assign start_edge = cnv_sync[1] & ~cnv_prev;

	// ---------------------------------------------------------------
	// phase sequencer
	// ---------------------------------------------------------------
	scs_state_t state;
	scs_state_t next_state;
	logic [4:0] step;
	logic [7:0] wake_cnt;
	logic       wake_done;
	logic       conv_done;

	assign wake_done = (wake_cnt == 8'(WAKE_CYC - 1));
	assign conv_done = (step == 5'(STEP_LAST));

	// start edges while busy are dropped; the host must not send them
	always_comb
	begin
		next_state = state;
		case (state)
			ST_SLEEP: if (start_edge) next_state = ST_WAKE;
			ST_ACQ:
			begin
				if (start_edge)
					next_state = ST_CONV;
				else if (pd_sync[1])
					next_state = ST_SLEEP;
			end
			ST_WAKE:  if (wake_done) next_state = ST_CONV;
			ST_CONV:  if (conv_done) next_state = ST_LATCH;
			ST_LATCH: next_state = pd_sync[1] ? ST_SLEEP : ST_ACQ;
			default:  next_state = ST_ACQ;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state <= ST_ACQ;
		else
			state <= next_state;
	end

	// wake delay lets the front end settle so the first result is good
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			wake_cnt <= 8'h00;
		else if (state == ST_WAKE)
			wake_cnt <= wake_cnt + 8'h01;
		else
			wake_cnt <= 8'h00;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			step <= STEP_RST;
		else if (state == ST_CONV)
			step <= step + 5'h01;
		else
			step <= STEP_RST;
	end

	// ---------------------------------------------------------------
	// pin flags
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			busy_or_clock_out <= 1'b0;
			track_hold        <= 1'b0;
			powered           <= 1'b1;
		end
		else
		begin
			// busy also spans the latch cycle so the word is already stored when it falls
			busy_or_clock_out <= (next_state == ST_WAKE) || (next_state == ST_CONV)
				|| (next_state == ST_LATCH);
			track_hold        <= (next_state == ST_CONV);
			powered           <= (next_state != ST_SLEEP);
		end
	end

	// ---------------------------------------------------------------
	// successive approximation: 24 difference steps, then 8 common-mode
	// ---------------------------------------------------------------
	logic [DIFF_W-1:0] diff_code;
	logic [CM_W-1:0]   cm_code;
	logic              cm_phase;
	logic [4:0]        cm_bit;
	logic [4:0]        diff_bit;

	assign cm_phase = (step >= 5'(DIFF_W));
	assign diff_bit = 5'(DIFF_W - 1) - step;
	assign cm_bit   = 5'(STEP_LAST) - step;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			diff_code <= DIFF_RST;
			cm_code   <= CM_RST;
		end
		else if (state != ST_CONV)
		begin
			diff_code <= DIFF_RST;
			cm_code   <= CM_RST;
		end
		else if (!cm_phase)
			diff_code[diff_bit] <= cmp_high;
		else
			cm_code[cm_bit[2:0]] <= cmp_high;
	end

	// trial value driven to the capacitor array; common-mode steps use the top byte
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sar_trial <= DIFF_RST;
		else if (next_state != ST_CONV)
			sar_trial <= DIFF_RST;
		else if (state != ST_CONV)
			sar_trial <= {1'b1, 23'h00_0000};
		else if (!cm_phase && step != 5'(DIFF_W - 1))
			sar_trial <= diff_code | (24'h80_0000 >> (step + 5'h01)) | (cmp_high ? (24'h80_0000 >> step) : 24'h00_0000);
		else if (!cm_phase)
			sar_trial <= {1'b1, 23'h00_0000};
		else
			// cm_bit counts down from 7, so weights are taken from the high end
			sar_trial <= {cm_code | (cmp_high ? (8'h01 << cm_bit[2:0]) : 8'h00)
				| (8'h01 << (cm_bit[2:0] - 3'h1)), 16'h0000};
	end

	// ---------------------------------------------------------------
	// output register: written once per conversion
	// ---------------------------------------------------------------
	logic [STORE_W-1:0] store_wr;
	logic [STORE_W-1:0] store_rd;
	logic [DIFF_W-1:0]  diff_twos;
	logic [CM_W-1:0]    cm_sel;

	// offset binary from the array becomes twos complement
	assign diff_twos = {~diff_code[DIFF_W-1], diff_code[DIFF_W-2:0]};
	assign cm_sel    = cm_append ? cm_code : cm_code_in & 8'h00;
	assign store_wr  = {echo_en, lane_mode, diff_twos, cm_sel};

	scs_result_store u_store (
		.mclk    (mclk),
		.rst     (rst),
		.wr_en   (state == ST_LATCH),
		.wr_data (store_wr),
		.rd_data (store_rd)
	);

	// ---------------------------------------------------------------
	// serial side on the host clock
	// ---------------------------------------------------------------
	// the stored word only changes at a latch, which the host avoids
	// during a frame, so it is read here as quasi-static data
	logic       frame_clear;
	logic [5:0] bit_idx;
	logic [2:0] lane_cnt;

	assign frame_clear = rst | cs_n;

	always_comb
	begin
		case (store_rd[CFG_LANE_LO+1:CFG_LANE_LO])
			LANES_TWO:  lane_cnt = 3'h2;
			LANES_FOUR: lane_cnt = 3'h4;
			default:    lane_cnt = 3'h1;
		endcase
	end

	function automatic logic lane_bit(input logic [WORD_W-1:0] word, input logic [5:0] idx,
		input logic [1:0] lane, input logic [2:0] lanes);
		logic [6:0] pos;
		begin
			pos = 7'(idx) + 7'(lane);
			if ({1'b0, lane} >= lanes || pos > 7'(DIFF_MSB))
				lane_bit = 1'b0;
			else
				lane_bit = word[5'(DIFF_MSB) - pos[4:0]];
		end
	endfunction : lane_bit

	always_ff @(posedge sck or posedge frame_clear)
	begin
		if (frame_clear)
		begin
			bit_idx <= IDX_RST;
			sdo     <= SDO_RST;
		end
		else
		begin
			for (int l = 0; l < 4; l++)
				sdo[l] <= lane_bit(store_rd[WORD_W-1:0], bit_idx, 2'(l), lane_cnt);
			if (bit_idx <= 6'(DIFF_MSB))
				bit_idx <= bit_idx + 6'(lane_cnt);
		end
	end

	// echo toggles once per data step so the host captures on both edges
	always_ff @(posedge sck or posedge frame_clear)
	begin
		if (frame_clear)
			echo_clock <= 1'b0;
		else if (store_rd[CFG_ECHO])
			echo_clock <= ~echo_clock;
	end

endmodule : scs_sequencer

`default_nettype wire

// [shared/scs_pkg.sv]
package scs_pkg;

	// ---------------------------------------------------------------
	// widths and result word layout
	// ---------------------------------------------------------------
	localparam int DIFF_W      = 24;
	localparam int CM_W        = 8;
	localparam int WORD_W      = 32;
	localparam int STORE_W     = 35;
	localparam int DIFF_MSB    = 31;
	localparam int CM_MSB      = 7;
	localparam int CFG_LANE_LO = 32;
	localparam int CFG_ECHO    = 34;
	localparam int STEP_LAST   = 31;

	// ---------------------------------------------------------------
	// lane modes on the lane_mode pins
	// ---------------------------------------------------------------
	localparam logic [1:0] LANES_ONE  = 2'h0;
	localparam logic [1:0] LANES_TWO  = 2'h1;
	localparam logic [1:0] LANES_FOUR = 2'h2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ      = 40;
	localparam int WAKE_TIME_NS = 250;
	localparam int WAKE_CYC     = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [DIFF_W-1:0]  DIFF_RST  = 24'h00_0000;
	localparam logic [CM_W-1:0]    CM_RST    = 8'h00;
	localparam logic [STORE_W-1:0] STORE_RST = 35'h0_0000_0000;
	localparam logic [4:0]         STEP_RST  = 5'h00;
	localparam logic [5:0]         IDX_RST   = 6'h00;
	localparam logic [3:0]         SDO_RST   = 4'h0;

	typedef enum logic [4:0] {
		ST_SLEEP = 5'h01,
		ST_ACQ   = 5'h02,
		ST_WAKE  = 5'h04,
		ST_CONV  = 5'h08,
		ST_LATCH = 5'h10
	} scs_state_t;

endpackage : scs_pkg

// [tb/scs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// host serial reader
// ----
module scs_host_model
(
	output var  logic       sck,
	output var  logic       cs_n,
	input  wire logic [3:0] sdo,
	input  wire logic       echo_clock
);
	logic [7:0] echo_hist;
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		echo_hist = 8'h00;
	end
	// sck stands low outside frames; sample on the falling edge
	task automatic read(input int n, output logic [31:0] w);
		int k, l;
		w = 32'h0000_0000;
		echo_hist = 8'h00;
		cs_n = 1'b0;
		#20;
		for (k = 0; k < 32 / n; k++)
		begin
			sck = 1'b1;
			#7.5 sck = 1'b0;
			for (l = 0; l < n; l++)
				w[31 - (k * n + l)] = sdo[l];
			echo_hist = {echo_hist[6:0], echo_clock};
			#7.5;
		end
		#10 cs_n = 1'b1;
	endtask : read
endmodule : scs_host_model
`default_nettype wire

// [tb/scs_seq_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// sequencer checks
// ----
module scs_seq_properties
	import scs_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic              convert_start,
	input wire logic              cs_n,
	input wire logic              busy_or_clock_out,
	input wire logic              track_hold,
	input wire logic [DIFF_W-1:0] sar_trial,
	input wire logic [3:0]        sdo
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic [7:0] cnt;
	// run length of busy, so the wake path may only lengthen it
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			cnt <= 8'h00;
		else
			cnt <= busy_or_clock_out ? cnt + 8'h01 : 8'h00;
	sequence conv_begin;
		$rose(track_hold) ##0 busy_or_clock_out;
	endsequence
	busy_th_a: assert property (track_hold |-> busy_or_clock_out) else $error("hold without busy");
	trial_mid_a: assert property ($rose(track_hold) |-> sar_trial == 24'h80_0000)
		else $error("bad first trial");
	busy_len_a: assert property ($fell(busy_or_clock_out) |-> cnt >= 8'h21) else $error("busy short");
	busy_end_a: assert property ($fell(busy_or_clock_out) |-> !track_hold) else $error("hold past busy");
	start_src_a: assert property ($rose(busy_or_clock_out) |->
		$past(convert_start, 3) || $past(convert_start, 4)) else $error("busy without start");
	sdo_idle_a: assert property (cs_n |-> sdo == 4'h0) else $error("sdo driven unselected");
	acq_gap_a: assert property ($fell(busy_or_clock_out) |=> !busy_or_clock_out)
		else $error("no acquire gap");
	conv_run_a: assert property (conv_begin |-> track_hold[*8]) else $error("conversion cut short");
endmodule : scs_seq_properties
bind scs_sequencer scs_seq_properties chk_i(.mclk, .rst, .convert_start, .cs_n, .busy_or_clock_out,
	.track_hold, .sar_trial, .sdo);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module tb;
	import scs_pkg::*;
	logic mclk = 0, rst = 1, convert_start = 0, power_down = 0, cm_append = 0, echo_en = 0, cmp_high = 0;
	logic [1:0]  lane_mode = LANES_ONE;
	logic [7:0]  cm_code_in = 8'h00, tc = 8'hA5;
	logic [23:0] tv = 24'h00_0000;
	wire logic busy_or_clock_out, track_hold, powered, echo_clock, sck, cs_n;
	wire logic [23:0] sar_trial;
	wire logic [3:0]  sdo;
	int err_total = 0, tests_run = 0, ph = 0;
	always #12.5 mclk = ~mclk;
	scs_sequencer dut(.*);
	scs_host_model host(.sck, .cs_n, .sdo, .echo_clock);
	// comparator stand-in: 24 difference steps, then common-mode steps
	always @(posedge mclk) ph <= track_hold ? ph + 1 : 0;
	always @(negedge mclk) cmp_high <= ph < 24 ? {~tv[23], tv[22:0]} >= sar_trial : tc >= sar_trial[23:16];
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task results;
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	task conv(output int n);
		int i;
		n = 0;
		convert_start = 1;
		for (i = 0; i < 300 && !(n > 0 && busy_or_clock_out === 1'b0); i++)
		begin
			@(negedge mclk);
			if (i == 5)
				convert_start = 0;
			n += busy_or_clock_out;
		end
		if (i == 300)
		begin
			err_total++;
			results();
		end
	endtask : conv
	task t_reset;
		chk("pwr", 1, powered);
		convert_start = 1;
		repeat (8) @(negedge mclk);
		convert_start = 0;
		chk("busy_hi", 1, busy_or_clock_out);
		#3 rst = 1;
		#1 chk("busy_rst", 0, busy_or_clock_out);
		chk("hold_rst", 0, track_hold);
		repeat (2) @(negedge mclk);
		rst = 0;
	endtask : t_reset
	task t_lanes;
		logic [23:0] v[3];
		logic [31:0] w;
		int i, n;
		v = '{24'h80_0000, 24'h7F_FFFF, 24'h12_3456};
		for (i = 0; i < 3; i++)
		begin
			@(negedge mclk);
			tv = v[i];
			cm_append = i != 1;
			lane_mode = 2'(i);
			echo_en = i == 2;
			conv(n);
			chk("busy_len", 33, n);
			host.read(1 << i, w);
			chk("word", {v[i], cm_append ? tc : 8'h00}, w);
			chk("echo", i == 2 ? 32'h0000_00AA : 32'h0000_0000, host.echo_hist);
		end
	endtask : t_lanes
	task t_sleep;
		logic [31:0] w;
		int n;
		@(negedge mclk);
		power_down = 1;
		repeat (10) @(negedge mclk);
		chk("sleep", 0, powered);
		tv = 24'hFF_FFFE;
		lane_mode = LANES_ONE;
		conv(n);
		chk("wake", 1, n > 33);
		host.read(1, w);
		chk("first", {tv, cm_append ? tc : 8'h00}, w);
		@(negedge mclk);
		power_down = 0;
	endtask : t_sleep
	initial
	begin
		repeat (3) @(negedge mclk);
		rst = 0;
		t_reset();
		t_lanes();
		t_sleep();
		results();
	end
endmodule : tb
`default_nettype wire
